/* vod_pkg.sv */
// shared constants for the valve output diagnostics block
package vod_pkg;
    localparam int NCH = 8;
    localparam int CW  = 26;                  // holds 65000 x 1000
    // register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_OPEN   = 8'h04;
    localparam logic [7:0] A_FSUB   = 8'h08;
    localparam logic [7:0] A_ISUB   = 8'h0C;
    localparam logic [7:0] A_CNTEN  = 8'h10;
    localparam logic [7:0] A_CNTCLR = 8'h14;
    localparam logic [7:0] A_STAT   = 8'h18;
    localparam logic [7:0] A_IRQST  = 8'h1C;
    localparam logic [7:0] A_IRQMK  = 8'h20;
    localparam logic [7:0] A_LIM0   = 8'h40;  // one word per channel
    localparam logic [7:0] A_CNT0   = 8'h60;  // one word per channel
    // control register fields
    localparam int C_CTLMON = 0;
    localparam int C_OUTMON = 1;
    localparam int C_SHORT  = 2;
    localparam int C_MANUAL = 3;
    localparam int C_SWPRIO = 4;
    localparam int C_PIN    = 8;              // 3 bits
    localparam int C_POUT   = 12;             // 3 bits
    localparam logic [31:0] CTRL_RST = 32'h0000_0005;
    // status / event bit positions
    localparam int E_CTL   = 0;
    localparam int E_OUT   = 1;
    localparam int E_SHORT = 2;
    localparam int E_OPEN  = 3;
    localparam int E_CNT   = 4;
    localparam int NEV     = 5;
    localparam int S_OPEN  = 8;
    localparam int S_CNT   = 16;
    localparam logic [15:0] LIM_RST = 16'h0001;
    localparam logic [9:0]  KILO    = 10'd1000;
    // substitution codes
    typedef enum logic [1:0] {
        VOD_CLEAR = 2'b00,
        VOD_HOLD  = 2'b01,
        VOD_FORCE_HIGH = 2'b10
    } vod_sub_t;
    // port speed / duplex codes
    localparam logic [2:0] PORT_AUTO = 3'h0;
    localparam logic [2:0] PORT_MAX  = 3'h4;  // 10h,10f,100h,100f follow auto
    // timing: one millisecond at 10 MHz, one hour in milliseconds
    localparam int CLK_HZ   = 10_000_000;
    localparam int MS_CYC   = CLK_HZ / 1000;
    localparam int HOUR_MS  = 3600 * 1000;
endpackage

/* vod_top.sv */
// valve output diagnostics: supply/short/open errors, substitution, op counters
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module vod_top #(
    parameter int MS_CYCLES = vod_pkg::MS_CYC,
    parameter int HOUR_MSEC = vod_pkg::HOUR_MS
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready_ff,
    output logic                          pslverr_ff,
    output logic [31:0]                   prdata_ff,
    input  wire logic                     ctl_sup_high,
    input  wire logic                     ctl_sup_low,
    input  wire logic                     out_sup_high,
    input  wire logic                     out_sup_low,
    input  wire logic                     short_seen,
    input  wire logic [vod_pkg::NCH-1:0]  open_seen,
    input  wire logic                     comm_fault,
    input  wire logic                     comm_idle,
    input  wire logic                     switch_hold,
    input  wire logic [vod_pkg::NCH-1:0]  out_cmd,
    input  wire logic                     nv_load_valid,
    input  wire logic [2:0]               nv_load_idx,
    input  wire logic [vod_pkg::CW-1:0]   nv_load_data,
    output logic                          nv_save_ff,
    output logic [2:0]                    nv_save_idx_ff,
    output logic [vod_pkg::CW-1:0]        nv_save_data_ff,
    output logic [vod_pkg::NCH-1:0]       valve_out_ff,
    output logic [2:0]                    port_in_mode_ff,
    output logic [2:0]                    port_out_mode_ff,
    output logic                          irq_ff
);
    localparam int NCH = vod_pkg::NCH;
    localparam int CW  = vod_pkg::CW;

    function automatic logic sub_bit(input logic [1:0] code, input logic held);
        unique case (code)
            vod_pkg::VOD_CLEAR:      sub_bit = 1'b0;
            vod_pkg::VOD_HOLD:       sub_bit = held;
            vod_pkg::VOD_FORCE_HIGH: sub_bit = 1'b1;
            default:                 sub_bit = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] word_of(input logic [7:0] a, input logic [7:0] base);
        word_of = 32'(a - base) >> 2;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0]          ctrl_ff;
    logic [NCH-1:0]       open_en_ff;
    logic [2*NCH-1:0]     fsub_ff;
    logic [2*NCH-1:0]     isub_ff;
    logic [NCH-1:0]       cnt_en_ff;
    logic [15:0]          lim_ff [NCH];
    logic [CW-1:0]        cnt_ff [NCH];
    logic                 ctl_err_ff;
    logic                 out_err_ff;
    logic                 short_err_ff;
    logic [NCH-1:0]       open_err_ff;
    logic [NCH-1:0]       cnt_err_ff;
    logic [vod_pkg::NEV-1:0] irq_st_ff;
    logic [vod_pkg::NEV-1:0] irq_mk_ff;
    logic [vod_pkg::NEV-1:0] ev_prev_ff;
    logic [vod_pkg::NEV-1:0] ev_now;
    logic                 wr_acc;
    logic                 setup;
    logic [31:0]          rd_word;
    logic                 rd_hit;
    logic [31:0]          lim_idx;
    logic [31:0]          cnt_idx;
    logic [NCH-1:0]       clr_req;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pready_ff & pwrite;
    assign lim_idx = word_of(paddr, vod_pkg::A_LIM0);
    assign cnt_idx = word_of(paddr, vod_pkg::A_CNT0);
    assign clr_req = (wr_acc && paddr == vod_pkg::A_CNTCLR) ? pwdata[NCH-1:0] : '0;

    // one wait-free access phase: ready rises in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~rd_hit;
            if (setup && !pwrite) begin
                prdata_ff <= rd_word;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            rd_hit = 1'b0;
        end else if (paddr >= vod_pkg::A_LIM0 && lim_idx < NCH) begin
            rd_word = {16'h0000, lim_ff[lim_idx[2:0]]};
        end else if (paddr >= vod_pkg::A_CNT0 && cnt_idx < NCH) begin
            rd_word = 32'(cnt_ff[cnt_idx[2:0]]);
        end else begin
            unique case (paddr)
                vod_pkg::A_CTRL:   rd_word = ctrl_ff;
                vod_pkg::A_OPEN:   rd_word = 32'(open_en_ff);
                vod_pkg::A_FSUB:   rd_word = 32'(fsub_ff);
                vod_pkg::A_ISUB:   rd_word = 32'(isub_ff);
                vod_pkg::A_CNTEN:  rd_word = 32'(cnt_en_ff);
                vod_pkg::A_CNTCLR: rd_word = 32'h0000_0000;
                vod_pkg::A_STAT: begin
                    rd_word[vod_pkg::E_CTL]   = ctl_err_ff;
                    rd_word[vod_pkg::E_OUT]   = out_err_ff;
                    rd_word[vod_pkg::E_SHORT] = short_err_ff;
                    rd_word[vod_pkg::S_OPEN +: NCH] = open_err_ff;
                    rd_word[vod_pkg::S_CNT +: NCH]  = cnt_err_ff;
                end
                vod_pkg::A_IRQST:  rd_word = 32'(irq_st_ff);
                vod_pkg::A_IRQMK:  rd_word = 32'(irq_mk_ff);
                default:           rd_hit  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= vod_pkg::CTRL_RST;
            open_en_ff <= '0;
            fsub_ff    <= '0;
            isub_ff    <= '0;
            cnt_en_ff  <= '0;
            irq_mk_ff  <= '0;
            for (int i = 0; i < NCH; i++) begin
                lim_ff[i] <= vod_pkg::LIM_RST;
            end
        end else if (wr_acc) begin
            // misaligned offsets inside the limit window must not land
            if (rd_hit && paddr >= vod_pkg::A_LIM0 && lim_idx < NCH) begin
                lim_ff[lim_idx[2:0]] <= pwdata[15:0];
            end
            unique case (paddr)
                vod_pkg::A_CTRL:  ctrl_ff    <= pwdata;
                vod_pkg::A_OPEN:  open_en_ff <= pwdata[NCH-1:0];
                vod_pkg::A_FSUB:  fsub_ff    <= pwdata[2*NCH-1:0];
                vod_pkg::A_ISUB:  isub_ff    <= pwdata[2*NCH-1:0];
                vod_pkg::A_CNTEN: cnt_en_ff  <= pwdata[NCH-1:0];
                vod_pkg::A_IRQMK: irq_mk_ff  <= pwdata[vod_pkg::NEV-1:0];
                default: ;
            endcase
        end
    end

    // out-of-range speed codes fall back to auto negotiation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_in_mode_ff  <= vod_pkg::PORT_AUTO;
            port_out_mode_ff <= vod_pkg::PORT_AUTO;
        end else begin
            port_in_mode_ff  <= (ctrl_ff[vod_pkg::C_PIN +: 3] > vod_pkg::PORT_MAX) ?
                                vod_pkg::PORT_AUTO : ctrl_ff[vod_pkg::C_PIN +: 3];
            port_out_mode_ff <= (ctrl_ff[vod_pkg::C_POUT +: 3] > vod_pkg::PORT_MAX) ?
                                vod_pkg::PORT_AUTO : ctrl_ff[vod_pkg::C_POUT +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supply, short and open errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_err_ff  <= 1'b0;
            out_err_ff  <= 1'b0;
            open_err_ff <= '0;
        end else begin
            ctl_err_ff  <= ctrl_ff[vod_pkg::C_CTLMON] & (ctl_sup_high | ctl_sup_low);
            out_err_ff  <= ctrl_ff[vod_pkg::C_OUTMON] & (out_sup_high | out_sup_low);
            open_err_ff <= open_en_ff & open_seen;
        end
    end

    // manual mode relies on presetn being the power-up reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_err_ff <= 1'b0;
        end else if (!ctrl_ff[vod_pkg::C_SHORT]) begin
            short_err_ff <= 1'b0;
        end else if (short_seen) begin
            short_err_ff <= 1'b1;
        end else if (!ctrl_ff[vod_pkg::C_MANUAL]) begin
            short_err_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output substitution; fault wins over idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valve_out_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!(comm_fault || comm_idle)) begin
                    valve_out_ff[i] <= out_cmd[i];
                end else if (ctrl_ff[vod_pkg::C_SWPRIO]) begin
                    valve_out_ff[i] <= sub_bit(comm_fault ? fsub_ff[2*i +: 2] :
                                               isub_ff[2*i +: 2], valve_out_ff[i]);
                end else begin
                    valve_out_ff[i] <= switch_hold & valve_out_ff[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operation counters, hourly save, restore after power-up
    logic [NCH-1:0] out_prev_ff;
    logic [31:0]    ms_cnt_ff;
    logic [31:0]    hr_cnt_ff;
    logic           saving_ff;
    logic [2:0]     save_ch_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_prev_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            out_prev_ff <= valve_out_ff;
            for (int i = 0; i < NCH; i++) begin
                if (clr_req[i]) begin
                    cnt_ff[i] <= '0;
                end else if (nv_load_valid && nv_load_idx == 3'(i)) begin
                    cnt_ff[i] <= nv_load_data;
                end else if (valve_out_ff[i] != out_prev_ff[i] && ~&cnt_ff[i]) begin
                    cnt_ff[i] <= cnt_ff[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_err_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                cnt_err_ff[i] <= cnt_en_ff[i] &
                                 (cnt_ff[i] > CW'(lim_ff[i] * vod_pkg::KILO));
            end
        end
    end

    // the hour is built from a millisecond tick to keep counters narrow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_ff       <= 32'h0000_0000;
            hr_cnt_ff       <= 32'h0000_0000;
            saving_ff       <= 1'b0;
            save_ch_ff      <= 3'h0;
            nv_save_ff      <= 1'b0;
            nv_save_idx_ff  <= 3'h0;
            nv_save_data_ff <= '0;
        end else begin
            nv_save_ff <= saving_ff;
            nv_save_idx_ff  <= save_ch_ff;
            nv_save_data_ff <= cnt_ff[save_ch_ff];
            if (saving_ff) begin
                save_ch_ff <= save_ch_ff + 3'h1;
                saving_ff  <= (save_ch_ff != 3'(NCH - 1));
            end
            if (ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
                ms_cnt_ff <= 32'h0000_0000;
                if (hr_cnt_ff == 32'(HOUR_MSEC - 1)) begin
                    hr_cnt_ff  <= 32'h0000_0000;
                    saving_ff  <= 1'b1;
                    save_ch_ff <= 3'h0;
                end else begin
                    hr_cnt_ff <= hr_cnt_ff + 32'h0000_0001;
                end
            end else begin
                ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: rising errors set sticky bits, set wins over write-one-clear
    assign ev_now = {|cnt_err_ff, |open_err_ff, short_err_ff, out_err_ff, ctl_err_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_prev_ff <= '0;
            irq_st_ff  <= '0;
            irq_ff     <= 1'b0;
        end else begin
            ev_prev_ff <= ev_now;
            irq_st_ff  <= (irq_st_ff & ~((wr_acc && paddr == vod_pkg::A_IRQST) ?
                          pwdata[vod_pkg::NEV-1:0] : '0)) | (ev_now & ~ev_prev_ff);
            irq_ff     <= |(irq_st_ff & irq_mk_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ctl_err_a: assert property ((ctl_sup_high || ctl_sup_low) && ctrl_ff[vod_pkg::C_CTLMON]
        |=> ctl_err_ff) else $error("control supply error missing");
    out_err_a: assert property (!ctrl_ff[vod_pkg::C_OUTMON] |=> !out_err_ff)
        else $error("output supply error while disabled");
    short_set_a: assert property (short_seen && ctrl_ff[vod_pkg::C_SHORT] |=> short_err_ff)
        else $error("short error not raised");
    short_auto_a: assert property (!short_seen && !ctrl_ff[vod_pkg::C_MANUAL] |=> !short_err_ff)
        else $error("auto restart did not clear");
    short_hold_a: assert property (short_err_ff && ctrl_ff[vod_pkg::C_MANUAL]
        && ctrl_ff[vod_pkg::C_SHORT] |=> short_err_ff)
        else $error("manual short error released");
    open_err_a: assert property (open_err_ff == $past(open_en_ff & open_seen))
        else $error("open error mismatch");
    sub_force_a: assert property (comm_fault && ctrl_ff[vod_pkg::C_SWPRIO]
        && fsub_ff[1:0] == vod_pkg::VOD_FORCE_HIGH |=> valve_out_ff[0])
        else $error("force high not applied");
    sub_switch_a: assert property ((comm_fault || comm_idle) && !ctrl_ff[vod_pkg::C_SWPRIO]
        && !switch_hold |=> !valve_out_ff[0]) else $error("switch clear ignored");
    cnt_clr_a: assert property (clr_req[0] |=> cnt_ff[0] == '0)
        else $error("counter not cleared");
    save_walk_a: assert property ($rose(saving_ff) |=> saving_ff [*7] ##1 !saving_ff)
        else $error("hourly save walk wrong length");

    fault_cov_c: cover property (comm_fault ##1 valve_out_ff[0]);
    short_cov_c: cover property ($rose(short_err_ff) ##[1:20] $fell(short_err_ff));
    irq_cov_c:   cover property ($rose(irq_ff));
endmodule

`default_nettype wire

/* vod_nv_model.sv */
// non-volatile count store standing in for the far side of the save/restore path
`timescale 1ns/10ps
`default_nettype none

module vod_nv_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   nv_save,
    input  wire logic [2:0]             nv_save_idx,
    input  wire logic [vod_pkg::CW-1:0] nv_save_data,
    output logic                        nv_load_valid,
    output logic [2:0]                  nv_load_idx,
    output logic [vod_pkg::CW-1:0]      nv_load_data
);
    logic [vod_pkg::CW-1:0] store_ff [vod_pkg::NCH] = '{default: '0};
    logic [3:0]             play_ff;

    ////////////////////////////////////////////////////////////////////////////
    // storage survives reset, so it is never cleared by presetn
    always @(posedge pclk) begin
        if (nv_save === 1'b1) begin
            store_ff[nv_save_idx] <= nv_save_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // replay all eight counts right after every power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            play_ff <= 4'h0;
        end else if (play_ff < 4'h8) begin
            play_ff <= play_ff + 4'h1;
        end
    end

    // idle bus shows the inverse of the last entry, never a stale copy
    always_comb begin
        nv_load_valid = presetn && (play_ff < 4'h8);
        if (nv_load_valid) begin
            nv_load_idx  = play_ff[2:0];
            nv_load_data = store_ff[play_ff[2:0]];
        end else begin
            nv_load_idx  = 3'h0;
            nv_load_data = ~store_ff[7];
        end
    end
endmodule

`default_nettype wire

/* test_valve_output_diagnostics.sv */
// self-checking bench for the valve output diagnostics block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module test_valve_output_diagnostics;
    logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_ff, lfsr_s;
    logic ctl_sup_high, ctl_sup_low, out_sup_high, out_sup_low, short_seen;
    logic comm_fault, comm_idle, switch_hold, nv_load_valid, nv_save_ff, irq_ff;
    logic [7:0] open_seen, out_cmd, valve_out_ff;
    logic [2:0] nv_load_idx, nv_save_idx_ff, port_in_mode_ff, port_out_mode_ff;
    logic [vod_pkg::CW-1:0] nv_load_data, nv_save_data_ff;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    int err_count, check_count;

    vod_top #(.MS_CYCLES(4), .HOUR_MSEC(3)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .prdata_ff(prdata_ff), .ctl_sup_high(ctl_sup_high), .ctl_sup_low(ctl_sup_low),
        .out_sup_high(out_sup_high), .out_sup_low(out_sup_low), .short_seen(short_seen),
        .open_seen(open_seen), .comm_fault(comm_fault), .comm_idle(comm_idle),
        .switch_hold(switch_hold), .out_cmd(out_cmd), .nv_load_valid(nv_load_valid),
        .nv_load_idx(nv_load_idx), .nv_load_data(nv_load_data), .nv_save_ff(nv_save_ff),
        .nv_save_idx_ff(nv_save_idx_ff), .nv_save_data_ff(nv_save_data_ff),
        .valve_out_ff(valve_out_ff), .port_in_mode_ff(port_in_mode_ff),
        .port_out_mode_ff(port_out_mode_ff), .irq_ff(irq_ff));

    vod_nv_model i_nv (.pclk(pclk), .presetn(presetn), .nv_save(nv_save_ff),
        .nv_save_idx(nv_save_idx_ff), .nv_save_data(nv_save_data_ff),
        .nv_load_valid(nv_load_valid), .nv_load_idx(nv_load_idx),
        .nv_load_data(nv_load_data));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        if (exp_q.size() != 0) err_count++;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // held until pready is seen high at a falling edge, released at the next rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(negedge pclk); n++; end while (pready_ff !== 1'b1 && n < 20);
        if (n >= 20) begin err_count++; tally_and_finish(); end
        @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // expected {pslverr, prdata} goes to the queue before the read starts
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic see_irq(input logic e);
        @(negedge pclk);
        `CHK(irq_ff, e)
        @(posedge pclk);
    endtask

    task automatic see_valve(input logic [7:0] e);
        @(negedge pclk);
        `CHK(valve_out_ff, e)
        @(posedge pclk);
    endtask

    always @(negedge pclk) begin
        if (psel && penable && pready_ff === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[FAIL] %0t got %h exp %h", $time, prdata_ff, 33'h0);
            end else begin
                exp_v = exp_q.pop_front();
                `CHK({pslverr_ff, prdata_ff}, exp_v)
            end
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] sub_exp(input logic [15:0] c, input logic [7:0] last);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) r[k] = (c[2*k +: 2] == 2'b01) ? last[k] : c[2*k+1] & ~c[2*k];
        return r;
    endfunction

    task automatic sub_case(input logic sw, input logic [15:0] fc, input logic [15:0] ic,
                            input logic f, input logic i, input logic swh);
        logic [7:0] last;
        repeat (8) lfsr_s = lfsr_next(lfsr_s);
        last = lfsr_s[7:0];
        wr(vod_pkg::A_CTRL, sw ? 32'h0000_0015 : 32'h0000_0005);
        wr(vod_pkg::A_FSUB, {16'h0000, fc});
        wr(vod_pkg::A_ISUB, {16'h0000, ic});
        switch_hold <= swh; out_cmd <= last;
        cyc(3);
        comm_fault <= f; comm_idle <= i;
        @(posedge pclk);
        out_cmd <= ~last;
        cyc(2);
        see_valve(sub_exp(!sw ? {8{1'b0, swh}} : (f ? fc : ic), last));
        comm_fault <= 1'b0; comm_idle <= 1'b0;
        cyc(2);
        see_valve(~last);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
        ctl_sup_high = 0; ctl_sup_low = 0; out_sup_high = 0; out_sup_low = 0;
        short_seen = 0; open_seen = 0; comm_fault = 0; comm_idle = 0;
        switch_hold = 0; out_cmd = 0; lfsr_s = 32'h0001_8672;
        err_count = 0; check_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(vod_pkg::A_CTRL, 33'h0_0000_0005);
        rd(vod_pkg::A_OPEN, 33'h0_0000_0000);
        rd(vod_pkg::A_FSUB, 33'h0_0000_0000);
        rd(vod_pkg::A_CNTEN, 33'h0_0000_0000);
        wr(8'h42, 32'h0000_0000);
        rd(vod_pkg::A_LIM0, 33'h0_0000_0001);
        rd(8'h30, 33'h1_0000_0000);
        rd(8'h02, 33'h1_0000_0000);
        ctl_sup_high <= 1'b1;
        cyc(3);
        rd(vod_pkg::A_STAT, 33'h0_0000_0001);
        ctl_sup_high <= 1'b0; ctl_sup_low <= 1'b1; out_sup_low <= 1'b1;
        cyc(3);
        rd(vod_pkg::A_STAT, 33'h0_0000_0001);
        wr(vod_pkg::A_CTRL, 32'h0000_0007);
        rd(vod_pkg::A_STAT, 33'h0_0000_0003);
        ctl_sup_low <= 1'b0; ctl_sup_high <= 1'b1; out_sup_low <= 1'b0; out_sup_high <= 1'b1;
        wr(vod_pkg::A_CTRL, 32'h0000_0006);
        rd(vod_pkg::A_STAT, 33'h0_0000_0002);
        ctl_sup_high <= 1'b0; out_sup_high <= 1'b0; short_seen <= 1'b1;
        wr(vod_pkg::A_CTRL, 32'h0000_0005);
        rd(vod_pkg::A_STAT, 33'h0_0000_0004);
        short_seen <= 1'b0;
        cyc(3);
        rd(vod_pkg::A_STAT, 33'h0_0000_0000);
        wr(vod_pkg::A_CTRL, 32'h0000_0001);
        short_seen <= 1'b1;
        cyc(3);
        rd(vod_pkg::A_STAT, 33'h0_0000_0000);
        short_seen <= 1'b0; open_seen <= 8'h28;
        wr(vod_pkg::A_CTRL, 32'h0000_0005);
        wr(vod_pkg::A_OPEN, 32'h0000_0008);
        rd(vod_pkg::A_STAT, 33'h0_0000_0800);
        open_seen <= 8'h00;
        wr(vod_pkg::A_IRQST, 32'h0000_001F);
        wr(vod_pkg::A_IRQMK, 32'h0000_0001);
        ctl_sup_high <= 1'b1;
        cyc(3);
        see_irq(1'b1);
        ctl_sup_high <= 1'b0;
        cyc(3);
        see_irq(1'b1);
        wr(vod_pkg::A_IRQST, 32'h0000_0001);
        see_irq(1'b0);
        short_seen <= 1'b1;
        cyc(3);
        see_irq(1'b0);
        rd(vod_pkg::A_IRQST, 33'h0_0000_0004);
        sub_case(1'b0, 16'hA6A6, 16'h6A6A, 1'b1, 1'b0, 1'b1);
        sub_case(1'b0, 16'hA6A6, 16'h6A6A, 1'b0, 1'b1, 1'b0);
        sub_case(1'b1, 16'h61E6, 16'h9B1E, 1'b1, 1'b0, 1'b0);
        sub_case(1'b1, 16'h61E6, 16'h9B1E, 1'b0, 1'b1, 1'b1);
        sub_case(1'b1, 16'h61E6, 16'h9B1E, 1'b1, 1'b1, 1'b0);
        short_seen <= 1'b0;
        for (int m = 0; m < 6; m++) begin
            wr(vod_pkg::A_CTRL, 32'h0000_0005 | (32'(m) << 8) | (32'(4 - m) << 12));
            @(negedge pclk);
            `CHK(port_in_mode_ff, 3'(m > 4 ? 0 : m))
            `CHK(port_out_mode_ff, 3'(m > 4 ? 0 : 4 - m))
            @(posedge pclk);
        end
        wr(vod_pkg::A_CTRL, 32'h0000_0005);
        out_cmd <= 8'h00;
        cyc(2);
        wr(vod_pkg::A_CNTCLR, 32'h0000_00FF);
        wr(vod_pkg::A_CNTEN, 32'h0000_0001);
        rd(vod_pkg::A_CNT0, 33'h0_0000_0000);
        repeat (1000) begin
            out_cmd[0] <= ~out_cmd[0];
            @(posedge pclk);
        end
        cyc(2);
        rd(vod_pkg::A_CNT0, 33'h0_0000_03E8);
        rd(vod_pkg::A_STAT, 33'h0_0000_0000);
        out_cmd[0] <= 1'b1;
        cyc(3);
        rd(vod_pkg::A_CNT0, 33'h0_0000_03E9);
        rd(vod_pkg::A_STAT, 33'h0_0001_0000);
        out_cmd[0] <= 1'b0;
        cyc(2);
        wr(vod_pkg::A_CNTCLR, 32'h0000_0001);
        rd(vod_pkg::A_CNT0, 33'h0_0000_0000);
        rd(vod_pkg::A_STAT, 33'h0_0000_0000);
        repeat (6) begin
            out_cmd[0] <= ~out_cmd[0];
            @(posedge pclk);
        end
        wr(vod_pkg::A_CTRL, 32'h0000_000D);
        short_seen <= 1'b1;
        cyc(3);
        short_seen <= 1'b0;
        cyc(40);
        rd(vod_pkg::A_STAT, 33'h0_0000_0004);
        `CHK(i_nv.store_ff[0], 26'h000_0006)
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(12);
        rd(vod_pkg::A_CNT0, 33'h0_0000_0006);
        rd(vod_pkg::A_STAT, 33'h0_0000_0000);
        tally_and_finish();
    end

    initial begin
        repeat (50000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
